// File: logic/fsx_decode.sv
/*
  Combinational decoder from opcode bytes to operation class, stack effect,
  destination choice and cycle count.
  Assumes the opcode bytes are stable for the cycle they are presented.
*/
`include "fsx_params.svh"

module fsx_decode
  import fsx_pkg::*;
(
  // Instruction bytes.
  input wire logic [7:0] esc,
  input wire logic [7:0] modrm,
  // Operand range hints from the datapath.
  input wire logic big_arg,
  input wire logic arg_quarter,
  input wire logic arg_half,
  input wire logic in_range,
  // Decoded result.
  output fsx_op_t op,
  output logic [1:0] pops,
  output logic push,
  output logic to_sti,
  output logic mem_int16,
  output logic [7:0] cycles
);

  wire [1:0] md = modrm[`FSX_MOD_HI:`FSX_MOD_LO];
  wire [2:0] rg = modrm[`FSX_REG_HI:`FSX_REG_LO];
  wire is_reg = (md == `FSX_MOD_REG);
  wire [15:0] full = {esc, modrm};
  wire rsvd = (full == `FSX_RSVD_0) || (full == `FSX_RSVD_1) ||
              (full == `FSX_RSVD_2) || (full == `FSX_RSVD_3) ||
              (full == `FSX_RSVD_4) || (full == `FSX_RSVD_5) ||
              (full == `FSX_RSVD_6) || (full == `FSX_RSVD_7) ||
              (full == `FSX_RSVD_8) || (full == `FSX_RSVD_9);
  wire [7:0] trig_extra = big_arg ? `FSX_CY_ARG_RED : 8'h00;

  // Opcode classification; reserved codes win and raise nothing.
  always_comb begin
    op = FSX_NONE;
    pops = 2'h0;
    push = 1'b0;
    to_sti = 1'b0;
    mem_int16 = 1'b0;
    cycles = `FSX_CY_UNKNOWN;
    if (rsvd) begin
      op = FSX_RSVD;
      cycles = `FSX_CY_RSVD;
    end else if (esc == `FSX_WAIT_OP) begin
      op = FSX_WAIT;
      cycles = `FSX_CY_WAIT;
    end else if ((esc == `FSX_ESC_D8 || esc == `FSX_ESC_DC ||
                  esc == `FSX_ESC_DE) && is_reg &&
                 (rg == `FSX_REG_E0 || rg == `FSX_REG_E8)) begin
      // Register forms: DC/DE with reg E8 and D8 with E0 are forward.
      op = ((esc == `FSX_ESC_D8) == (rg == `FSX_REG_E0)) ? FSX_SUB
                                                          : FSX_SUBR;
      to_sti = (esc != `FSX_ESC_D8);
      pops = (esc == `FSX_ESC_DE) ? 2'h1 : 2'h0;
      cycles = `FSX_CY_SUB_MAX;
    end else if ((esc == `FSX_ESC_D8 || esc == `FSX_ESC_DC) && !is_reg &&
                 (rg == `FSX_REG_SUB || rg == `FSX_REG_SUBR)) begin
      op = (rg == `FSX_REG_SUB) ? FSX_SUB : FSX_SUBR;
      cycles = `FSX_CY_SUB_MAX;
    end else if ((esc == `FSX_ESC_DA || esc == `FSX_ESC_DE) && !is_reg &&
                 (rg == `FSX_REG_SUB || rg == `FSX_REG_SUBR)) begin
      op = (rg == `FSX_REG_SUB) ? FSX_ISUB : FSX_ISUBR;
      mem_int16 = (esc == `FSX_ESC_DE);
      cycles = (mem_int16 && rg == `FSX_REG_SUBR) ? `FSX_CY_ISUBR16_MAX
                                                   : `FSX_CY_ISUB_MAX;
    end else if (esc == `FSX_ESC_DD && is_reg &&
                 (rg == `FSX_REG_E0 || rg == `FSX_REG_E8)) begin
      op = FSX_UCOM;
      pops = (rg == `FSX_REG_E8) ? 2'h1 : 2'h0;
      cycles = `FSX_CY_CMP;
    end else if (esc == `FSX_ESC_DA && modrm == `FSX_OP_UCOMPP) begin
      op = FSX_UCOM;
      pops = 2'h2;
      cycles = `FSX_CY_CMP;
    end else if (esc == `FSX_ESC_D9 && is_reg && rg == `FSX_REG_C8) begin
      op = FSX_XCH;
      cycles = `FSX_CY_XCH;
    end else if (esc == `FSX_ESC_D9) begin
      unique case (modrm)
        `FSX_OP_TST: begin
          op = FSX_TST;
          cycles = `FSX_CY_CMP;
        end
        `FSX_OP_XAM: begin
          op = FSX_XAM;
          cycles = `FSX_CY_CMP;
        end
        `FSX_OP_EXTRACT: begin
          op = FSX_EXTRACT;
          push = 1'b1;
          cycles = `FSX_CY_EXT_MAX;
        end
        `FSX_OP_YL2X: begin
          op = FSX_YL2X;
          pops = 2'h1;
          cycles = `FSX_CY_YL2X_MAX;
        end
        `FSX_OP_YL2XP1: begin
          op = FSX_YL2XP1;
          pops = 2'h1;
          cycles = in_range ? `FSX_CY_YL2XP1_MAX
                            : `FSX_CY_YL2XP1_FALL;
        end
        `FSX_OP_COS: begin
          op = FSX_COS;
          cycles = (arg_quarter ? `FSX_CY_COS_SMALL
                   : (arg_half ? `FSX_CY_COS_MID : `FSX_CY_SIN_MAX))
                   + trig_extra;
        end
        `FSX_OP_SIN: begin
          op = FSX_SIN;
          cycles = (arg_quarter ? `FSX_CY_SIN_SMALL : `FSX_CY_SIN_MAX)
                   + trig_extra;
        end
        `FSX_OP_SINCOS: begin
          op = FSX_SINCOS;
          push = 1'b1;
          cycles = `FSX_CY_SINCOS + trig_extra;
        end
        `FSX_OP_TAN: begin
          op = FSX_TAN;
          push = 1'b1;
          cycles = `FSX_CY_TAN + trig_extra;
        end
        `FSX_OP_EXP2M1: begin
          op = FSX_EXP2M1;
          cycles = arg_half ? `FSX_CY_EXP2_SMALL : `FSX_CY_EXP2;
        end
        `FSX_OP_ATAN: begin
          op = FSX_ATAN;
          pops = 2'h1;
          cycles = in_range ? `FSX_CY_ATAN_SMALL : `FSX_CY_ATAN;
        end
        default: begin
          op = FSX_NONE;
        end
      endcase
    end
  end

endmodule : fsx_decode

// File: logic/fsx_params.svh
/*
  Timing constants and opcode encodings for the subtract, compare and
  miscellaneous floating-point decode block.
  Assumes a single 50 MHz core clock; every count below is in core clocks.
*/
`ifndef FSX_PARAMS_SVH
`define FSX_PARAMS_SVH

// Escape bytes of the floating-point opcode space.
`define FSX_ESC_D8 8'hd8
`define FSX_ESC_D9 8'hd9
`define FSX_ESC_DA 8'hda
`define FSX_ESC_DC 8'hdc
`define FSX_ESC_DD 8'hdd
`define FSX_ESC_DE 8'hde
`define FSX_ESC_DF 8'hdf
`define FSX_WAIT_OP 8'h9b

// Fixed second bytes.
`define FSX_OP_TST 8'he4
`define FSX_OP_XAM 8'he5
`define FSX_OP_EXTRACT 8'hf4
`define FSX_OP_YL2X 8'hf1
`define FSX_OP_YL2XP1 8'hf9
`define FSX_OP_UCOMPP 8'he9
`define FSX_OP_COS 8'hff
`define FSX_OP_SIN 8'hfe
`define FSX_OP_SINCOS 8'hfb
`define FSX_OP_TAN 8'hf2
`define FSX_OP_EXP2M1 8'hf0
`define FSX_OP_ATAN 8'hf3

// Reserved two-byte opcodes; they retire quietly as a short no-op.
`define FSX_RSVD_0 16'hd9d7
`define FSX_RSVD_1 16'hd9e2
`define FSX_RSVD_2 16'hd9e7
`define FSX_RSVD_3 16'hddfc
`define FSX_RSVD_4 16'hded8
`define FSX_RSVD_5 16'hdeda
`define FSX_RSVD_6 16'hdedc
`define FSX_RSVD_7 16'hdedd
`define FSX_RSVD_8 16'hdede
`define FSX_RSVD_9 16'hdffc

// Modrm field positions.
`define FSX_MOD_HI 7
`define FSX_MOD_LO 6
`define FSX_REG_HI 5
`define FSX_REG_LO 3
`define FSX_RM_HI 2
`define FSX_RM_LO 0
`define FSX_MOD_REG 2'h3
`define FSX_REG_SUB 3'h4
`define FSX_REG_SUBR 3'h5
`define FSX_REG_E0 3'h4
`define FSX_REG_E8 3'h5
`define FSX_REG_C8 3'h1

// Cycle counts, least and most.
`define FSX_CY_SUB_MIN 8'h04
`define FSX_CY_SUB_MAX 8'h09
`define FSX_CY_ISUB_MIN 8'h0e
`define FSX_CY_ISUB_MAX 8'h1d
`define FSX_CY_ISUBR16_MAX 8'h1b
`define FSX_CY_CMP 8'h04
`define FSX_CY_WAIT 8'h02
`define FSX_CY_XCH 8'h03
`define FSX_CY_EXT_MIN 8'h0b
`define FSX_CY_EXT_MAX 8'h10
`define FSX_CY_YL2X_MIN 8'h91
`define FSX_CY_YL2X_MAX 8'h9a
`define FSX_CY_YL2XP1_MIN 8'h83
`define FSX_CY_YL2XP1_MAX 8'h85
`define FSX_CY_YL2XP1_FALL 8'haa
`define FSX_CY_ARG_RED 8'h5a
`define FSX_CY_COS_SMALL 8'h8d
`define FSX_CY_COS_MID 8'h5c
`define FSX_CY_SIN_SMALL 8'h51
`define FSX_CY_SIN_MAX 8'h8c
`define FSX_CY_SINCOS 8'h91
`define FSX_CY_TAN 8'h75
`define FSX_CY_EXP2_SMALL 8'h5c
`define FSX_CY_EXP2 8'h5c
`define FSX_CY_ATAN_SMALL 8'h61
`define FSX_CY_ATAN 8'ha1
`define FSX_CY_RSVD 8'h02
`define FSX_CY_UNKNOWN 8'h02

`endif

// File: logic/fsx_pkg.sv
/*
  Types for the floating-point subtract/compare/misc decode block.
  Assumes the constants header is included by the files that need numbers.
*/
package fsx_pkg;

  // Operation class produced by the decoder.
  typedef enum logic [4:0] {
    FSX_NONE, FSX_SUB, FSX_SUBR, FSX_ISUB, FSX_ISUBR, FSX_TST, FSX_UCOM,
    FSX_WAIT, FSX_XAM, FSX_XCH, FSX_EXTRACT, FSX_YL2X, FSX_YL2XP1,
    FSX_COS, FSX_SIN, FSX_SINCOS, FSX_TAN, FSX_EXP2M1, FSX_ATAN, FSX_RSVD
  } fsx_op_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    FSX_IDLE, FSX_BUSY, FSX_HOLD
  } fsx_state_t;

endpackage : fsx_pkg

// File: logic/fsx_stack.sv
/*
  Stack-top pointer of the eight-entry register stack.
  Assumes pops and pushes are applied once, when an operation retires.
*/
`include "fsx_params.svh"

module fsx_stack
  import fsx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic apply,
  input wire logic [1:0] pops,
  input wire logic push,
  output logic [2:0] top
);

  // Pops add, a push subtracts; popped values are simply abandoned.
  wire [2:0] next_top = top + {1'b0, pops} - {2'h0, push};

  // Pointer update on retire only.
  always_ff @(posedge clk) begin
    if (rst) begin
      top <= 3'h0;
    end else if (apply) begin
      top <= next_top;
    end
  end

endmodule : fsx_stack

// File: logic/fsx_exec.sv
/*
  Decode and timing sequencer for subtract, compare, classify, exchange,
  extract, logarithm and trigonometric floating-point operations.
  Assumes the integer unit presents one opcode with a one-cycle dispatch
  pulse while READY is high; the datapath supplies range hints.
*/
// Summary of operation
// - Forward subtract: register or memory real from top, 4-9 cycles.
// - Subtract-and-pop stores register minus top, then pops, 4-9 cycles.
// - Reverse subtract swaps operand order, 4-9 cycles.
// - Reverse subtract pop: top minus register into register, then pop.
// - Integer subtract of 32/16-bit memory from top, 14-29 cycles.
// - Reversed integer subtract: 32-bit 14-29, 16-bit 14-27 cycles.
// - Compare top with zero sets condition bits in 4 cycles.
// - Unordered compare in 4 cycles, with no, one or two pops.
// - Wait stalls until unit idle, 2 cycles when not stalled.
// - Classify loads condition bits with class of top, 4 cycles.
// - Exchange top with selected register in 3 cycles.
// - Extract exponent then push significand, 11-16 cycles.
// - Y times log2 of top into second register, pop, 145-154 cycles.
// - Log2 plus one variant 131-133 cycles, 170 when out of range.
// - Operand registers resolve against the stack before execution.
// - Pops increment the top pointer, pushes decrement; popped data lost.
// - Trig functions add 90 cycles of reduction for large arguments.
// - Cosine 141 cycles below quarter pi, 92 between quarter and half.
// - Sine 81-82 cycles below quarter pi.
// - Two-to-x-minus-one 92 cycles when top below one half.
// - Partial arctangent 97 cycles when ratio below pi over 32.
// - Ten reserved opcodes raise no exception; results unpredictable.
`include "fsx_params.svh"

module fsx_exec
  import fsx_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Dispatch from the integer unit.
  input wire logic DISPATCH,
  input wire logic [7:0] ESC_BYTE,
  input wire logic [7:0] MODRM_BYTE,
  output logic READY,
  // Operand range hints from the datapath.
  input wire logic ARG_BEYOND_REDUCE,
  input wire logic ARG_BELOW_QUARTER_PI,
  input wire logic ARG_BELOW_HALF,
  input wire logic ARG_IN_RANGE,
  // Condition outcome from the datapath, sampled at retire.
  input wire logic [3:0] COND_RESULT,
  // Execution status.
  output logic BUSY,
  output logic DONE,
  output logic [4:0] OP_CLASS,
  output logic [2:0] STACK_TOP,
  output logic [2:0] SRC_INDEX,
  output logic [2:0] DST_INDEX,
  output logic WRITE_STI,
  output logic REVERSED,
  output logic MEM_INT16,
  output logic [3:0] CONDITION_CODE_BITS,
  output logic [7:0] CYCLE_COUNT
);

  fsx_state_t state;
  fsx_op_t dec_op;
  fsx_op_t cur_op;
  logic [1:0] dec_pops;
  logic dec_push;
  logic dec_to_sti;
  logic dec_int16;
  logic [7:0] dec_cycles;
  logic [7:0] remain;
  logic [1:0] cur_pops;
  logic cur_push;
  logic [2:0] top;
  logic [3:0] cc;

  // Opcode decode, including data-dependent timing.
  fsx_decode u_decode (
    .esc(ESC_BYTE),
    .modrm(MODRM_BYTE),
    .big_arg(ARG_BEYOND_REDUCE),
    .arg_quarter(ARG_BELOW_QUARTER_PI),
    .arg_half(ARG_BELOW_HALF),
    .in_range(ARG_IN_RANGE),
    .op(dec_op),
    .pops(dec_pops),
    .push(dec_push),
    .to_sti(dec_to_sti),
    .mem_int16(dec_int16),
    .cycles(dec_cycles)
  );

  // Dispatch and retire strobes.
  wire take = DISPATCH && (state == FSX_IDLE);
  wire last = (state == FSX_BUSY) && (remain == 8'h01);
  wire [2:0] rel = MODRM_BYTE[`FSX_RM_HI:`FSX_RM_LO];
  wire cc_op = (cur_op == FSX_TST) || (cur_op == FSX_UCOM) ||
               (cur_op == FSX_XAM);

  // Pointer moves only at retire, so operands use the old arrangement.
  fsx_stack u_stack (
    .clk(REF_CLK),
    .rst(RST),
    .apply(last),
    .pops(cur_pops),
    .push(cur_push),
    .top(top)
  );

  assign READY = (state == FSX_IDLE);
  assign BUSY = (state != FSX_IDLE);
  assign STACK_TOP = top;
  assign CONDITION_CODE_BITS = cc;

  // Sequencer: the count is loaded at dispatch and runs to the result.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= FSX_IDLE;
      remain <= 8'h00;
    end else if (take) begin
      state <= FSX_BUSY;
      remain <= dec_cycles;
    end else if (state == FSX_BUSY) begin
      remain <= remain - 8'h01;
      if (last) begin
        state <= FSX_IDLE;
      end
    end
  end

  // Latched operation details for the datapath.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cur_op <= FSX_NONE;
      cur_pops <= 2'h0;
      cur_push <= 1'b0;
      OP_CLASS <= 5'h00;
      SRC_INDEX <= 3'h0;
      DST_INDEX <= 3'h0;
      WRITE_STI <= 1'b0;
      REVERSED <= 1'b0;
      MEM_INT16 <= 1'b0;
      CYCLE_COUNT <= 8'h00;
    end else if (take) begin
      cur_op <= dec_op;
      cur_pops <= dec_pops;
      cur_push <= dec_push;
      OP_CLASS <= dec_op;
      SRC_INDEX <= top + rel;
      DST_INDEX <= dec_to_sti ? top + rel : top;
      WRITE_STI <= dec_to_sti;
      REVERSED <= (dec_op == FSX_SUBR) || (dec_op == FSX_ISUBR);
      MEM_INT16 <= dec_int16;
      CYCLE_COUNT <= dec_cycles;
    end
  end

  // Condition bits load at retire for compare and classify operations.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cc <= 4'h0;
      DONE <= 1'b0;
    end else begin
      DONE <= last;
      if (last && cc_op) begin
        cc <= COND_RESULT;
      end
    end
  end

endmodule : fsx_exec

// File: verification/fsx_iu_model.sv
/*
  Behavioural integer unit that dispatches floating-point opcodes.
  Assumes the bench calls issue from a falling clock edge.
*/
module fsx_iu_model (
  // Core clock and unit readiness.
  input wire logic clk,
  input wire logic ready,
  // Dispatch lines toward the unit.
  output logic dispatch,
  output logic [7:0] esc,
  output logic [7:0] modrm
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lines idle low before the first request.
  initial begin
    dispatch = 1'b0;
    esc = 8'h00;
    modrm = 8'h00;
  end

  // Waits for readiness unless told to offer into a busy unit on purpose.
  // Reserved codes go out only when the bench asks for them.
  task automatic issue(input logic [7:0] e, m, input int gap, input bit hold);
    int k;
    repeat (gap) @(negedge clk);
    for (k = 0; hold && ready !== 1'b1 && k < 400; k++) begin
      @(negedge clk);
    end
    dispatch = 1'b1;
    esc = e;
    modrm = m;
    @(negedge clk);
    // Released bytes show the inverse, so a stale value cannot pass.
    dispatch = 1'b0;
    esc = ~e;
    modrm = ~m;
  endtask : issue
endmodule : fsx_iu_model

// File: verification/fsx_exec_sva.sv
/*
  Port timing checks of the floating-point decode sequencer.
  Assumes one clock and a synchronous active-high reset; bound to the top.
*/
module fsx_exec_sva (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Dispatch handshake.
  input wire logic DISPATCH,
  input wire logic [7:0] ESC_BYTE,
  input wire logic [7:0] MODRM_BYTE,
  input wire logic READY,
  // Execution status.
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [2:0] STACK_TOP,
  input wire logic [7:0] CYCLE_COUNT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Accepted request and the second byte's fields.
  wire take = DISPATCH && READY;
  wire mem_form = MODRM_BYTE[7:6] != 2'h3;
  wire [2:0] fld = MODRM_BYTE[5:3];
  logic [7:0] run_len;

  // Busy cycles so far, so the length can meet the loaded count.
  always_ff @(posedge REF_CLK) begin
    if (RST || !BUSY) begin
      run_len <= 8'h00;
    end else begin
      run_len <= run_len + 8'h01;
    end
  end

  // One opcode taken, and the retire step that ends every operation.
  sequence s_take(logic [7:0] e, logic [7:0] m);
    take && ESC_BYTE == e && MODRM_BYTE == m;
  endsequence
  sequence s_retire;
    !BUSY && READY && DONE;
  endsequence

  a_busy_not_ready: assert property (BUSY |-> !READY)
    else $error("ready while busy");
  a_take_busy: assert property (take |=> BUSY && !DONE)
    else $error("take did not start");
  a_done_pulse: assert property (
    DONE |-> $past(BUSY) && !BUSY ##1 !DONE)
    else $error("done not a pulse");
  a_busy_length: assert property (
    $fell(BUSY) |-> run_len == CYCLE_COUNT)
    else $error("busy length off");
  a_sub_count: assert property (
    take && ESC_BYTE == 8'hd8 && fld == 3'h4 |=> CYCLE_COUNT == 8'h09)
    else $error("subtract count");
  a_isub_count: assert property (
    take && ESC_BYTE == 8'hda && mem_form && fld == 3'h4
    |=> CYCLE_COUNT == 8'h1d) else $error("isub count");
  a_test_steps: assert property (
    s_take(8'hd9, 8'he4) |=> BUSY[*4] ##1 s_retire)
    else $error("test timing");
  a_xch_steps: assert property (
    take && ESC_BYTE == 8'hd9 && MODRM_BYTE[7:3] == 5'h19
    |=> BUSY[*3] ##1 s_retire) else $error("exchange timing");
  a_popp_top: assert property (
    s_take(8'hda, 8'he9) |=> BUSY[*4] ##1 s_retire
    ##0 STACK_TOP == 3'($past(STACK_TOP, 5) + 3'h2))
    else $error("double pop");
  a_extract_top: assert property (
    s_take(8'hd9, 8'hf4) |-> ##16 BUSY ##1 s_retire
    ##0 STACK_TOP == 3'($past(STACK_TOP, 17) - 3'h1))
    else $error("extract push");
  a_rsvd_steps: assert property (
    s_take(8'hd9, 8'hd7) |=> BUSY[*2] ##1 s_retire)
    else $error("reserved timing");
endmodule : fsx_exec_sva

// File: verification/test_fsx_exec.sv
/*
  Self-checking bench: every operation class except FSX_NONE, reserved codes, a refused
  dispatch and a reset in mid-run.
  Assumes the package and the integer-unit model are compiled first.
*/
module test_fsx_exec
  import fsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Inputs, each with a value at time zero.
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic beyond = 1'b0;
  logic quarter = 1'b0;
  logic half = 1'b0;
  logic in_range = 1'b0;
  logic [3:0] cond = 4'h0;
  logic dispatch;
  logic [7:0] esc;
  logic [7:0] modrm;
  logic ready, busy, done, write_sti, rev, m16;
  logic [4:0] op_class;
  logic [2:0] stack_top, dst, src;
  logic [3:0] cc;
  logic [7:0] cycles;
  int num_errors = 0;
  int n_checks = 0;
  logic [15:0] lfsr = 16'hb2a3;
  logic [2:0] exp_top = 3'h0;
  logic [3:0] exp_cc = 4'h0;
  logic [7:0] nbusy = 8'h00;
  wire [2:0] n = lfsr[8:6];
  wire [3:0] rh = lfsr[12:9];
  logic [15:0] rsv [10] = '{16'hd9d7, 16'hd9e2, 16'hd9e7, 16'hddfc,
    16'hded8, 16'hdeda, 16'hdedc, 16'hdedd, 16'hdede, 16'hdffc};

  always #10 ref_clk = ~ref_clk;

  fsx_exec fsx_exec_inst (.REF_CLK(ref_clk), .RST(rst),
    .DISPATCH(dispatch), .ESC_BYTE(esc), .MODRM_BYTE(modrm), .READY(ready),
    .ARG_BEYOND_REDUCE(beyond), .ARG_BELOW_QUARTER_PI(quarter),
    .ARG_BELOW_HALF(half), .ARG_IN_RANGE(in_range), .COND_RESULT(cond),
    .BUSY(busy), .DONE(done), .OP_CLASS(op_class), .STACK_TOP(stack_top),
    .SRC_INDEX(src), .DST_INDEX(dst), .WRITE_STI(write_sti),
    .REVERSED(rev), .MEM_INT16(m16), .CONDITION_CODE_BITS(cc),
    .CYCLE_COUNT(cycles));
  fsx_iu_model iu_inst (.clk(ref_clk), .ready(ready), .dispatch(dispatch),
    .esc(esc), .modrm(modrm));

  // Busy length measured here, independent of the unit's own count.
  always @(posedge ref_clk) begin
    nbusy <= (busy === 1'b1) ? nbusy + 8'h01 : 8'h00;
  end

  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : rnd

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [7:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %b", $time, what, got);
    end
  endtask : chk_bit

  // One operation; f holds push, busy poke, compare and index flags.
  task automatic op(input logic [7:0] e, m, input logic [3:0] h,
      input fsx_op_t xo, input logic [7:0] xc, input int pp,
      input logic [3:0] f);
    int k;
    logic [2:0] xs;
    logic [2:0] xd;
    logic xr;
    logic x16;
    xs = exp_top + m[2:0];
    xd = f[0] ? xs : exp_top;
    xr = (xo == FSX_SUBR) || (xo == FSX_ISUBR);
    x16 = (e == 8'hde) && (xo == FSX_ISUB || xo == FSX_ISUBR);
    lfsr = rnd(lfsr);
    {beyond, quarter, half, in_range} = h;
    cond = lfsr[3:0];
    iu_inst.issue(e, m, int'(lfsr[5:4]), 1'b1);
    if (f[2]) iu_inst.issue(8'hd9, 8'he4, 1, 1'b0);
    for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge ref_clk);
    chk_bit(ready, 1'b1, "ready");
    chk_val(nbusy, xc, "length");
    chk_val(cycles, xc, "count");
    chk_val({3'h0, op_class}, {3'h0, xo}, "class");
    chk_bit(rev, xr, "rev");
    chk_bit(m16, x16, "int16");
    if (f[1]) exp_cc = cond;
    if (pp >= 0) begin
      chk_val({5'h0, dst}, {5'h0, xd}, "dst");
      chk_bit(write_sti, f[0], "sti");
      if (m[7:6] == 2'h3) chk_val({5'h0, src}, {5'h0, xs}, "src");
      exp_top = exp_top + pp[2:0] - {2'h0, f[3]};
      chk_val({5'h0, stack_top}, {5'h0, exp_top}, "top");
      chk_val({4'h0, cc}, {4'h0, exp_cc}, "cc");
    end
    $display("op %h %h done", e, m);
  endtask : op

  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    op(8'hd8, {5'h1c, n}, rh, FSX_SUB, 8'h09, 0, 4'h0);
    op(8'hdc, {5'h04, n}, rh, FSX_SUB, 8'h09, 0, 4'h0);
    op(8'hde, {5'h1d, n}, rh, FSX_SUB, 8'h09, 1, 4'h1);
    op(8'hdc, {5'h0d, n}, rh, FSX_SUBR, 8'h09, 0, 4'h0);
    op(8'hde, {5'h1c, n}, rh, FSX_SUBR, 8'h09, 1, 4'h1);
    op(8'hda, {5'h04, n}, rh, FSX_ISUB, 8'h1d, 0, 4'h0);
    op(8'hde, {5'h14, n}, rh, FSX_ISUB, 8'h1d, 0, 4'h0);
    op(8'hde, {5'h0d, n}, rh, FSX_ISUBR, 8'h1b, 0, 4'h0);
    op(8'hd9, 8'he4, rh, FSX_TST, 8'h04, 0, 4'h2);
    op(8'hdd, {5'h1c, n}, rh, FSX_UCOM, 8'h04, 0, 4'h2);
    op(8'hdd, {5'h1d, n}, rh, FSX_UCOM, 8'h04, 1, 4'h2);
    op(8'hda, 8'he9, rh, FSX_UCOM, 8'h04, 2, 4'h2);
    op(8'h9b, 8'h00, rh, FSX_WAIT, 8'h02, 0, 4'h0);
    op(8'hd9, 8'he5, rh, FSX_XAM, 8'h04, 0, 4'h2);
    op(8'hd9, {5'h19, n}, rh, FSX_XCH, 8'h03, 0, 4'h0);
    op(8'hd9, 8'hf4, rh, FSX_EXTRACT, 8'h10, 0, 4'h8);
    op(8'hd9, 8'hf1, rh, FSX_YL2X, 8'h9a, 1, 4'h4);
    op(8'hd9, 8'hf9, 4'h1, FSX_YL2XP1, 8'h85, 1, 4'h0);
    op(8'hd9, 8'hf9, 4'h0, FSX_YL2XP1, 8'haa, 1, 4'h0);
    op(8'hd9, 8'hff, 4'h4, FSX_COS, 8'h8d, 0, 4'h0);
    op(8'hd9, 8'hff, 4'h2, FSX_COS, 8'h5c, 0, 4'h0);
    op(8'hd9, 8'hfe, 4'h4, FSX_SIN, 8'h51, 0, 4'h0);
    op(8'hd9, 8'hfe, 4'h8, FSX_SIN, 8'he6, 0, 4'h0);
    op(8'hd9, 8'hf0, 4'h2, FSX_EXP2M1, 8'h5c, 0, 4'h0);
    op(8'hdc, {5'h1d, n}, rh, FSX_SUB, 8'h09, 0, 4'h1);
    op(8'hd9, 8'hfb, 4'h0, FSX_SINCOS, 8'h91, 0, 4'h8);
    op(8'hd9, 8'hf2, 4'h8, FSX_TAN, 8'hcf, 0, 4'h8);
    op(8'hd9, 8'hf3, 4'h1, FSX_ATAN, 8'h61, 1, 4'h0);
    op(8'hd9, 8'hf3, 4'h0, FSX_ATAN, 8'ha1, 1, 4'h0);
    foreach (rsv[i]) begin
      op(rsv[i][15:8], rsv[i][7:0], rh, FSX_RSVD, 8'h02, -1, 4'h0);
    end
    // Reset while a long logarithm is still busy must abandon it cleanly.
    iu_inst.issue(8'hd9, 8'hf1, 0, 1'b1);
    repeat (5) @(negedge ref_clk);
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    chk_bit(busy, 1'b0, "reset busy");
    chk_bit(done, 1'b0, "reset done");
    chk_val({5'h0, stack_top}, 8'h00, "reset top");
    chk_val({4'h0, cc}, 8'h00, "reset cc");
    exp_top = 3'h0;
    exp_cc = 4'h0;
    op(8'hd9, 8'hf4, rh, FSX_EXTRACT, 8'h10, 0, 4'h8);
    stop_test();
  end

  // Watchdog sized well above the sum of all operation lengths.
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end
endmodule : test_fsx_exec

bind fsx_exec fsx_exec_sva fsx_exec_sva_inst (.REF_CLK(REF_CLK), .RST(RST),
  .DISPATCH(DISPATCH), .ESC_BYTE(ESC_BYTE), .MODRM_BYTE(MODRM_BYTE),
  .READY(READY), .BUSY(BUSY), .DONE(DONE), .STACK_TOP(STACK_TOP),
  .CYCLE_COUNT(CYCLE_COUNT));
